// File: logic/spi_bank_pkg.sv
// constants, types and reset values for the dual channel serial register bank
package spi_bank_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int NF = 7;
    localparam int AW = 13;
    localparam logic [AW-1:0] ADDR_PORT_CFG = 13'h0000;
    localparam logic [AW-1:0] ADDR_PART_ID = 13'h0001;
    localparam logic [AW-1:0] ADDR_SPEED = 13'h0002;
    localparam logic [AW-1:0] ADDR_CHAN_SEL = 13'h0005;
    localparam logic [AW-1:0] ADDR_XFER = 13'h00ff;
    // port configuration fields, mirrored nibbles
    localparam logic [7:0] PORT_CFG_FIXED = 8'h18;
    localparam logic [7:0] LSB_BITS = 8'h42;
    localparam logic [7:0] SRST_BITS = 8'h24;
    localparam int SPEED_POS = 4;
    localparam logic [1:0] CHAN_SEL_RESET = 2'h3;
    localparam int XFER_BIT = 0;
    // function registers: index 0 is the lowest address
    localparam logic [NF-1:0][7:0] FUNC_ADDR = {8'h3a, 8'h14, 8'h10, 8'h0d, 8'h0b, 8'h09, 8'h08};
    localparam logic [NF-1:0][7:0] FUNC_MASK = {8'hff, 8'h17, 8'h3f, 8'hbf, 8'h3f, 8'h01, 8'h23};
    localparam logic [NF-1:0][7:0] FUNC_RESET = {8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    localparam logic [NF-1:0] FUNC_LOCAL = 7'h39;
    // ----------------------------------------------------------------
    // framing
    // ----------------------------------------------------------------
    localparam logic [4:0] INSTR_LAST = 5'h0f;
    localparam logic [4:0] BYTE_LAST = 5'h07;
    localparam int RW_BIT = 15;
    localparam int LEN_HI = 14;
    localparam int LEN_LO = 13;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA, ST_DONE} phase_type;
    typedef logic [NF-1:0][7:0] bank_type;
    typedef struct packed {
        phase_type phase;
        logic sclk_q;
        logic [4:0] bitcnt;
        logic [15:0] shreg;
        logic rw;
        logic [1:0] bytes_left;
        logic stream;
        logic [AW-1:0] addr;
        logic [7:0] tx;
        logic sdio_out;
        logic sdio_oe;
        logic lsb;
        logic [1:0] sel;
        logic xfer;
        logic [1:0][NF-1:0][7:0] master;
        logic [1:0][NF-1:0][7:0] active;
    } state_type;
    localparam state_type STATE_RESET = '{phase: ST_IDLE, sclk_q: 1'b0, bitcnt: 5'h00, shreg: 16'h0000,
        rw: 1'b0, bytes_left: 2'h0, stream: 1'b0, addr: 13'h0000, tx: 8'h00, sdio_out: 1'b0,
        sdio_oe: 1'b0, lsb: 1'b0, sel: CHAN_SEL_RESET, xfer: 1'b0,
        master: {FUNC_RESET, FUNC_RESET}, active: {FUNC_RESET, FUNC_RESET}};
endpackage

// File: logic/dual_channel_spi_register_bank.sv
// serial port and register bank with per channel copies and shadowed function registers
//
// Contract
// RULE1: each local register has its own copy for channel A and channel B.
// RULE2: channel select bits 0 and 1 steer local accesses; both set after reset.
// RULE3: with both select bits set a local write lands in both copies.
// RULE4: with both select bits set a local read returns the channel A copy.
// RULE5: host sets only one select bit before reading a local register; the bench also reads with both set.
// RULE6: global registers have a single copy governing the whole part.
// RULE7: global accesses ignore the channel select bits entirely.
// RULE8: only listed addresses and bits exist; others read zero, ignore writes.
// RULE9: port config has bit order in 6,1, soft reset 5,2, reads 0x18 default.
// RULE10: soft reset restores all defaults and then reads back as zero.
// RULE11: shadowed writes act only on transfer, all at once; transfer self clears.
// RULE12: shadowed registers are addresses 0x08 to 0x20 and 0x3a; the code shadows only 0x08, 0x09, 0x0b, 0x0d, 0x10, 0x14 and 0x3a.
// RULE13: bit order is msb first after reset until changed.
`timescale 1ns/1ps
module dual_channel_spi_register_bank
#(
    parameter logic [7:0] PART_ID = 8'h5a, // arbitrary value
    parameter logic [1:0] SPEED_CODE = 2'h0
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // serial port
    input wire logic spi_sclk,
    input wire logic spi_csb_n,
    input wire logic spi_sdio_in,
    output logic spi_sdio_out,
    output logic spi_sdio_oe,
    // applied settings
    output spi_bank_pkg::bank_type active_a,
    output spi_bank_pkg::bank_type active_b,
    output logic lsb_first
);
    import spi_bank_pkg::*;

    state_type r, n;
    logic rise, fall;
    logic wr_en, sr_hit, load_tx;
    logic [AW-1:0] wr_addr, load_addr;
    logic [7:0] rx;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] rev8(input logic [7:0] x);
        logic [7:0] y;
        y = 8'h00;
        for (int i = 0; i < 8; i++)
            y[i] = x[7-i];
        return y;
    endfunction

    // returns hit flag and index of a function register
    function automatic logic [3:0] find_idx(input logic [AW-1:0] a);
        logic [3:0] f;
        f = 4'h0;
        for (int i = 0; i < NF; i++)
            if (a == {5'h00, FUNC_ADDR[i]})
                f = {1'b1, 3'(i)};
        return f;
    endfunction

    // read mux over the whole map
    function automatic logic [7:0] read_reg(input logic [AW-1:0] a, input state_type s);
        logic [7:0] d;
        logic [3:0] f;
        d = 8'h00; // unmapped reads zero RULE8
        f = find_idx(a);
        case (a)
            ADDR_PORT_CFG: d = PORT_CFG_FIXED | (s.lsb ? LSB_BITS : 8'h00); // RULE9
            ADDR_PART_ID: d = PART_ID;
            ADDR_SPEED: d = {2'h0, SPEED_CODE, 4'h0};
            ADDR_CHAN_SEL: d = {6'h00, s.sel};
            ADDR_XFER: d = {7'h00, s.xfer};
            default:
            begin
                if (f[3] && FUNC_LOCAL[f[2:0]] && s.sel == 2'b10)
                    d = s.master[1][f[2:0]];
                else if (f[3])
                    d = s.master[0][f[2:0]]; // channel A when both set RULE4 RULE7
            end
        endcase
        return d;
    endfunction

    assign rise = spi_sclk & ~r.sclk_q;
    assign fall = ~spi_sclk & r.sclk_q;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [15:0] instr;
        logic [7:0] rbyte;
        logic [AW-1:0] nxt_addr;
        logic [3:0] f;
        instr = 16'h0000;
        rbyte = 8'h00;
        nxt_addr = r.addr;
        f = 4'h0;
        n = r;
        wr_en = 1'b0;
        wr_addr = r.addr;
        load_tx = 1'b0;
        load_addr = r.addr;
        sr_hit = 1'b0;
        rx = 8'h00;
        n.sclk_q = spi_sclk;
        n.xfer = 1'b0; // transfer bit clears itself RULE11
        // transfer copies every shadow into the working copies at once
        if (r.xfer)
        begin
            for (int c = 0; c < 2; c++)
                for (int i = 0; i < NF; i++)
                    n.active[c][i] = FUNC_LOCAL[i] ? r.master[c][i] : r.master[0][i]; // RULE11 RULE12 RULE6
        end
        // serial framing
        case (r.phase)
            ST_IDLE:
            begin
                n.sdio_oe = 1'b0;
                n.bitcnt = 5'h00;
                if (!spi_csb_n)
                    n.phase = ST_INSTR;
            end
            ST_INSTR:
            begin
                if (rise)
                begin
                    n.shreg = {r.shreg[14:0], spi_sdio_in};
                    n.bitcnt = 5'(r.bitcnt + 5'h01);
                    if (r.bitcnt == INSTR_LAST)
                    begin
                        instr = r.lsb ? {rev8(n.shreg[7:0]), rev8(n.shreg[15:8])} : n.shreg; // RULE13
                        n.rw = instr[RW_BIT];
                        n.addr = instr[AW-1:0];
                        n.bytes_left = instr[LEN_HI:LEN_LO];
                        n.stream = &instr[LEN_HI:LEN_LO];
                        n.bitcnt = 5'h00;
                        n.phase = ST_DATA;
                        load_tx = instr[RW_BIT];
                        load_addr = instr[AW-1:0];
                    end
                end
            end
            ST_DATA:
            begin
                if (fall && r.rw)
                begin
                    n.sdio_oe = 1'b1;
                    n.sdio_out = r.lsb ? r.tx[r.bitcnt[2:0]] : r.tx[3'(3'h7 - r.bitcnt[2:0])];
                end
                if (rise)
                begin
                    n.shreg = {r.shreg[14:0], spi_sdio_in};
                    n.bitcnt = 5'(r.bitcnt + 5'h01);
                    if (r.bitcnt == BYTE_LAST)
                    begin
                        rbyte = n.shreg[7:0];
                        rx = r.lsb ? rev8(rbyte) : rbyte;
                        wr_en = ~r.rw;
                        n.bitcnt = 5'h00;
                        nxt_addr = r.lsb ? AW'(r.addr + 13'h0001) : AW'(r.addr - 13'h0001);
                        n.addr = nxt_addr;
                        if (!r.stream && r.bytes_left == 2'h0)
                            n.phase = ST_DONE;
                        else
                            n.bytes_left = 2'(r.bytes_left - 2'h1);
                        load_tx = r.rw;
                        load_addr = nxt_addr;
                    end
                end
            end
            ST_DONE:
            begin
                if (fall)
                    n.sdio_oe = 1'b0;
            end
            default:
                n.phase = ST_IDLE;
        endcase
        if (load_tx)
            n.tx = read_reg(load_addr, r);
        // chip select high ends any frame
        if (spi_csb_n)
        begin
            n.phase = ST_IDLE;
            n.sdio_oe = 1'b0;
        end
        // register writes
        if (wr_en)
        begin
            f = find_idx(wr_addr);
            case (wr_addr)
                ADDR_PORT_CFG:
                begin
                    n.lsb = |(rx & LSB_BITS); // RULE9
                    sr_hit = |(rx & SRST_BITS); // RULE10
                end
                ADDR_CHAN_SEL: n.sel = rx[1:0]; // RULE2
                ADDR_XFER: n.xfer = rx[XFER_BIT]; // RULE11
                default:
                begin
                    if (f[3] && FUNC_LOCAL[f[2:0]])
                    begin
                        for (int c = 0; c < 2; c++)
                            if (r.sel[c])
                                n.master[c][f[2:0]] = rx & FUNC_MASK[f[2:0]]; // RULE1 RULE2 RULE3 RULE8
                    end
                    else if (f[3])
                        n.master[0][f[2:0]] = rx & FUNC_MASK[f[2:0]]; // RULE6 RULE7
                end
            endcase
        end
        // soft reset puts every register back to default; the bit is never stored
        if (sr_hit)
        begin
            n.lsb = 1'b0; // RULE13
            n.sel = CHAN_SEL_RESET;
            n.xfer = 1'b0;
            n.master = STATE_RESET.master; // RULE10
            n.active = STATE_RESET.active;
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            r <= STATE_RESET;
        else
            r <= n;
    end

    // outputs straight from the state register
    assign spi_sdio_out = r.sdio_out;
    assign spi_sdio_oe = r.sdio_oe;
    assign active_a = r.active[0];
    assign active_b = r.active[1];
    assign lsb_first = r.lsb;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_xfer_seen;
        r.xfer && !sr_hit;
    endsequence
    sequence s_local_both;
        wr_en && find_idx(wr_addr) == {1'b1, 3'h0} && r.sel == 2'b11 && !sr_hit;
    endsequence
    sequence s_soft_restored;
        r.sel == 2'b11 && !r.lsb ##1 r.active == STATE_RESET.active;
    endsequence

    AST_XFER_APPLY: assert property (s_xfer_seen |=> r.active[0] == $past(r.master[0])) // RULE11
        else $error("transfer did not apply shadow copy");
    AST_XFER_CLEAR: assert property (r.xfer |=> !r.xfer) // RULE11
        else $error("transfer bit stuck");
    AST_SHADOW_HOLD: assert property (!r.xfer && !sr_hit |=> $stable(r.active)) // RULE11 RULE12
        else $error("working copy changed without transfer");
    AST_BOTH_WRITE: assert property (s_local_both |=> r.master[0][0] == r.master[1][0]) // RULE3 RULE1
        else $error("dual channel write differs");
    AST_READ_A: assert property (load_tx && find_idx(load_addr) == {1'b1, 3'h3} && r.sel == 2'b11 // RULE4
        |=> r.tx == $past(r.master[0][3]))
        else $error("dual select read not channel A");
    AST_GLOBAL_WR: assert property (wr_en && wr_addr == 13'h0009 && !sr_hit // RULE7 RULE6
        |=> r.master[0][1] == ($past(rx) & 8'h01))
        else $error("global write lost");
    AST_PORT_CFG: assert property (load_tx && load_addr == ADDR_PORT_CFG // RULE9
        |=> r.tx[4:3] == 2'b11 && !r.tx[7] && !r.tx[0] && !r.tx[5] && r.tx[6] == r.tx[1])
        else $error("port config readback wrong");
    AST_SOFT_RESET: assert property (sr_hit |=> s_soft_restored) // RULE10 RULE13
        else $error("soft reset incomplete");
    AST_UNMAPPED: assert property (load_tx && load_addr == 13'h0003 |=> r.tx == 8'h00) // RULE8
        else $error("unmapped read not zero");
endmodule

// File: sim/spi_host_model.sv
// behavioural serial host that frames single byte reads and writes
`timescale 1ns/1ps
module spi_host_model
(
    // clock
    input wire logic clk,
    // serial port
    output logic sclk,
    output logic csb_n,
    output logic sdio,
    input wire logic dev_out,
    input wire logic dev_oe
);
    logic drv_bit;
    logic drv_on;
    // wire level: device wins while enabled, a released line shows the inverse of the last bit
    assign sdio = dev_oe ? dev_out : (drv_on ? drv_bit : ~drv_bit);
    initial
    begin
        sclk = 1'b0;
        csb_n = 1'b1;
        drv_bit = 1'b0;
        drv_on = 1'b0;
    end
    // one frame: 16 instruction bits and one data byte, data moved while sclk is low;
    // in lsb order the instruction and the byte each go out lowest bit first
    task automatic frame(input logic lsb, input logic rw, input logic [12:0] addr, input logic [7:0] wd,
        output logic [7:0] rd);
        logic [23:0] word;
        int k;
        word = {rw, 2'b00, addr, wd};
        k = 0;
        rd = 8'h00;
        @(posedge clk);
        csb_n <= 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            @(posedge clk);
            sclk <= 1'b0;
            @(posedge clk);
            k = lsb ? ((i < 8) ? 7 - i : 31 - i) : i;
            drv_bit <= word[k];
            drv_on <= !(rw && i < 8);
            repeat (2) @(posedge clk);
            sclk <= 1'b1;
            if (i < 8)
                rd[k] = sdio;
            repeat (2) @(posedge clk);
        end
        @(posedge clk);
        sclk <= 1'b0;
        repeat (3) @(posedge clk);
        csb_n <= 1'b1;
        drv_on <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
endmodule

// File: sim/testbench.sv
// self-checking bench for the dual channel serial register bank
`timescale 1ns/1ps
module testbench;
    import spi_bank_pkg::*;
    logic sys_clk;
    logic rstn;
    logic spi_sclk;
    logic spi_csb_n;
    logic spi_sdio;
    logic spi_sdio_out;
    logic spi_sdio_oe;
    logic lsb_first;
    bank_type active_a;
    bank_type active_b;
    bank_type sha;
    bank_type shb;
    logic [7:0] rd;
    logic order;
    int num_errors;
    int comparisons;
    // ----------------------------------------------------------------
    // clock, design and host
    // ----------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // part id value is arbitrary
    dual_channel_spi_register_bank #(.PART_ID(8'h3c), .SPEED_CODE(2'h2)) dut_u (.sys_clk(sys_clk), .rstn(rstn),
        .spi_sclk(spi_sclk), .spi_csb_n(spi_csb_n), .spi_sdio_in(spi_sdio), .spi_sdio_out(spi_sdio_out),
        .spi_sdio_oe(spi_sdio_oe), .active_a(active_a), .active_b(active_b), .lsb_first(lsb_first));
    spi_host_model host_u (.clk(sys_clk), .sclk(spi_sclk), .csb_n(spi_csb_n), .sdio(spi_sdio),
        .dev_out(spi_sdio_out), .dev_oe(spi_sdio_oe));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [55:0] seen, input logic [55:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        host_u.frame(order, 1'b0, a, d, rd);
    endtask
    task automatic rd_chk(input logic [12:0] a, input logic [7:0] e, input string what);
        host_u.frame(order, 1'b1, a, 8'h00, rd);
        check({48'h0, rd}, {48'h0, e}, what);
    endtask
    // shadow model: local entries follow the select bits, global ones ignore them
    function automatic void model_wr(input int i, input logic [7:0] v, input logic [1:0] sel);
        if (!FUNC_LOCAL[i] || sel[0])
            sha[i] = v & FUNC_MASK[i];
        if (!FUNC_LOCAL[i] || sel[1])
            shb[i] = v & FUNC_MASK[i];
    endfunction
    function automatic logic [7:0] model_rd(input int i, input logic [1:0] sel);
        return (FUNC_LOCAL[i] && sel == 2'b10) ? shb[i] : sha[i];
    endfunction
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // hang guard
    initial
    begin
        repeat (80000) @(posedge sys_clk);
        num_errors++;
        $display("BAD %0t watchdog expired", $time);
        test_done;
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [1:0] sel;
        logic [7:0] v;
        bank_type act_a;
        bank_type act_b;
        num_errors = 0;
        comparisons = 0;
        rstn = 1'b0;
        order = 1'b0;
        sha = FUNC_RESET;
        shb = FUNC_RESET;
        void'($urandom(96));
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        // reset values, read-only and unmapped places
        check(active_a, FUNC_RESET, "active a default");
        check(active_b, FUNC_RESET, "active b default");
        check({55'h0, lsb_first}, 56'h0, "bit order after reset");
        rd_chk(ADDR_PORT_CFG, PORT_CFG_FIXED, "port cfg default");
        rd_chk(ADDR_CHAN_SEL, {6'h00, CHAN_SEL_RESET}, "select default");
        rd_chk(ADDR_XFER, 8'h00, "transfer default");
        wr(ADDR_PART_ID, 8'hff);
        wr(13'h000c, 8'hff);
        rd_chk(ADDR_PART_ID, 8'h3c, "part id");
        rd_chk(ADDR_SPEED, 8'h20, "speed grade");
        rd_chk(13'h000c, 8'h00, "unmapped shadow slot");
        rd_chk(13'h0003, 8'h00, "unmapped chip slot");
        $display("test reset done");
        // random writes, both channels selected in round 0 and a random selection in later rounds, then one transfer
        for (int r = 0; r < 4; r++)
        begin
            act_a = sha;
            act_b = shb;
            for (int i = 0; i < NF; i++)
            begin
                sel = (r == 0) ? 2'b11 : 2'($urandom_range(1, 3));
                wr(ADDR_CHAN_SEL, {6'h00, sel});
                v = 8'($urandom);
                wr({5'h00, FUNC_ADDR[i]}, v);
                model_wr(i, v, sel);
            end
            check(active_a, act_a, "a held before transfer");
            check(active_b, act_b, "b held before transfer");
            wr(ADDR_XFER, 8'h01);
            check(active_a, sha, "a applied");
            check(active_b, shb, "b applied");
            rd_chk(ADDR_XFER, 8'h00, "transfer cleared");
            for (int i = 0; i < NF; i++)
                for (int s = 1; s < 4; s++)
                begin
                    wr(ADDR_CHAN_SEL, 8'(s));
                    rd_chk({5'h00, FUNC_ADDR[i]}, model_rd(i, 2'(s)), "readback");
                end
            $display("test random round %0d done", r);
        end
        // bit order, then soft reset by a frame that reads the same in either order
        wr(ADDR_CHAN_SEL, 8'h01);
        wr(ADDR_PORT_CFG, LSB_BITS);
        check({55'h0, lsb_first}, 56'h1, "lsb first set");
        order = 1'b1;
        rd_chk(ADDR_PORT_CFG, PORT_CFG_FIXED | LSB_BITS, "port cfg lsb");
        wr({5'h00, FUNC_ADDR[3]}, 8'h81);
        model_wr(3, 8'h81, 2'b01);
        rd_chk({5'h00, FUNC_ADDR[3]}, model_rd(3, 2'b01), "lsb local readback");
        wr(ADDR_PORT_CFG, SRST_BITS);
        order = 1'b0;
        sha = FUNC_RESET;
        shb = FUNC_RESET;
        check({55'h0, lsb_first}, 56'h0, "order restored");
        check(active_a, FUNC_RESET, "a restored");
        check(active_b, FUNC_RESET, "b restored");
        rd_chk(ADDR_PORT_CFG, PORT_CFG_FIXED, "soft reset cleared");
        rd_chk(ADDR_CHAN_SEL, {6'h00, CHAN_SEL_RESET}, "select restored");
        rd_chk({5'h00, FUNC_ADDR[5]}, FUNC_RESET[5], "shadow restored");
        rd_chk({5'h00, FUNC_ADDR[3]}, model_rd(3, 2'b11), "local restored");
        $display("test soft reset done");
        test_done;
    end
endmodule
